/* hw/tmas_pkg.sv */
// package: register map, field positions and reset values of the timer mode / match-A status block
package tmas_pkg;
  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_MATCH_A = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_COUNT2 = 8'h0C;
  localparam logic [7:0] ADDR_GEN_A = 8'h10;
  localparam logic [7:0] ADDR_GEN_B = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h30;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h34;
  localparam logic [7:0] ADDR_GEN_STRIDE = 8'h0C;
  // ----------------------------------------------------------------
  // reset values and fixed bits
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_RESET = 8'h98;
  localparam logic [7:0] MODE_FIXED_ONES = 8'h98;
  localparam logic [7:0] MATCH_A_RESET = 8'h88;
  localparam logic [7:0] MATCH_A_FIXED_ONES = 8'h88;
  localparam logic [15:0] GEN_RESET = 16'hFFFF;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MODE_QUAD_BIT = 6;
  localparam int MODE_OVF_COND_BIT = 5;
  localparam int MATCH_A_EN_LSB = 4;
  localparam int CTRL_CAPTURE_LSB = 0;
  localparam int CTRL_INIT_LSB = 4;
  localparam int IRQ_OVF_BIT = 3;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
endpackage : tmas_pkg

/* hw/tmas_top.sv */
// module: three-channel timer mode select, channel 2 quadrature count, match-A flags, AXI4-Lite slave
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
// Overview of operation
// R1: mode register loads 0x98 on reset or standby entry.
// R2: mode bits 7, 4, 3 ignore writes and read as one.
// R3: mode bit 6 selects channel 2 quadrature counting, reset zero.
// R4: quadrature mode counts channel 2 up/down on both edges of both inputs.
// R5: down on A rise/B low etc.; up for opposite pairings.
// R6: in quadrature mode the edge and prescale selections of channel 2 are ignored.
// R7: clear selection, compare, capture and interrupts keep working in quadrature mode; the code has no counter clear selection at all.
// R8: mode bit 5: zero flags overflow or underflow, one flags overflow only.
// R9: mode bits 2..0 put channels 2..0 into PWM mode, reset zero.
// R10: PWM output goes high on match A, low on match B.
// R11: match-A status register loads 0x88 on reset or standby entry.
// R12: match-A status bits 7 and 3 ignore writes and read as one.
// R13: bits 6..4 enable channel A interrupts; irq while flag and enable both set.
// R14: bits 2..0 flag counter equals general A in compare mode.
// R15: flag also sets on input capture into general A.
// R16: software clears a flag by reading it as one then writing zero.
// R17: writing one, or zero without prior read of one, leaves flag unchanged.
module tmas_top #(
  parameter int NCHAN = 3
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic standby,
  input wire logic quad_input_a,
  input wire logic quad_input_b,
  input wire logic [NCHAN-1:0] count_tick,
  input wire logic [NCHAN-1:0] capture_in,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [NCHAN-1:0] pwm_out_pin,
  output logic [NCHAN-1:0] match_a_irq,
  output logic irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] mode_reg;
  logic [NCHAN-1:0] a_en_reg;
  logic [NCHAN-1:0] a_flag_reg;
  logic [NCHAN-1:0] a_armed_reg;
  logic [NCHAN-1:0] capture_mode_reg;
  logic [NCHAN-1:0] out_init_reg;
  logic [15:0] count_reg [NCHAN];
  logic [15:0] gen_a_reg [NCHAN];
  logic [15:0] gen_b_reg [NCHAN];
  logic [NCHAN-1:0] pwm_reg;
  logic [3:0] irq_stat_reg;
  logic [3:0] irq_mask_reg;
  logic standby_d_reg;
  logic [2:0] qa_sync_reg;
  logic [2:0] qb_sync_reg;
  logic [NCHAN-1:0] cap_d_reg;
  logic aw_full_reg;
  logic w_full_reg;
  logic [31:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic irq_reg;
  logic [NCHAN-1:0] match_a_irq_reg;
  // standby entry acts as a reset of the two status/mode registers
  logic soft_init;
  assign soft_init = rst | (standby & ~standby_d_reg); // R1 R11
  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic wr_fire;
  logic rd_fire;
  logic [7:0] wa;
  logic [7:0] ra;
  logic wr_mode;
  logic wr_match;
  logic [NCHAN-1:0] wr_gen_a;
  logic [NCHAN-1:0] wr_gen_b;
  logic [NCHAN-1:0] wr_count;
  assign wr_fire = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign rd_fire = s_axi_arvalid & ~rvalid_reg;
  assign wa = awaddr_reg[7:0];
  assign ra = s_axi_araddr[7:0];
  assign wr_mode = wr_fire & (wa == tmas_pkg::ADDR_MODE) & wstrb_reg[0];
  assign wr_match = wr_fire & (wa == tmas_pkg::ADDR_MATCH_A) & wstrb_reg[0];
  // ----------------------------------------------------------------
  // quadrature input synchronisers and edge decode
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      qa_sync_reg <= 3'h0;
      qb_sync_reg <= 3'h0;
    end else begin
      qa_sync_reg <= {qa_sync_reg[1:0], quad_input_a};
      qb_sync_reg <= {qb_sync_reg[1:0], quad_input_b};
    end
  end
  // stage 1 vs 2 comparison marks a settled change; stage 0 is never looked at
  logic a_rise, a_fall, b_rise, b_fall, a_lvl, b_lvl;
  assign a_rise = qa_sync_reg[1] & ~qa_sync_reg[2];
  assign a_fall = ~qa_sync_reg[1] & qa_sync_reg[2];
  assign b_rise = qb_sync_reg[1] & ~qb_sync_reg[2];
  assign b_fall = ~qb_sync_reg[1] & qb_sync_reg[2];
  assign a_lvl = qa_sync_reg[2];
  assign b_lvl = qb_sync_reg[2];
  logic q_down, q_up;
  assign q_down = (a_rise & ~b_lvl) | (b_rise & a_lvl) | (a_fall & b_lvl) | (b_fall & ~a_lvl); // R5
  assign q_up = (a_rise & b_lvl) | (b_rise & ~a_lvl) | (a_fall & ~b_lvl) | (b_fall & a_lvl); // R5
  logic quad_mode;
  assign quad_mode = mode_reg[tmas_pkg::MODE_QUAD_BIT]; // R3
  // ----------------------------------------------------------------
  // per channel counter, compare, capture, PWM and match-A flag
  // ----------------------------------------------------------------
  logic [NCHAN-1:0] match_a_ev;
  logic ch2_ovf, ch2_unf;
  genvar g;
  generate
    for (g = 0; g < NCHAN; g++) begin : g_chan
      logic up, down, match_a, match_b, cap_ev, clr_req, set_req;
      assign wr_count[g] = wr_fire & (wa == tmas_pkg::ADDR_COUNT2 + 8'(g) * tmas_pkg::ADDR_GEN_STRIDE)
                           & (g == NCHAN - 1);
      assign wr_gen_a[g] = wr_fire & (wa == tmas_pkg::ADDR_GEN_A + 8'(g) * tmas_pkg::ADDR_GEN_STRIDE);
      assign wr_gen_b[g] = wr_fire & (wa == tmas_pkg::ADDR_GEN_B + 8'(g) * tmas_pkg::ADDR_GEN_STRIDE);
      // quadrature takes over the tick source of the last channel only
      assign up = (g == NCHAN - 1 && quad_mode) ? q_up : count_tick[g]; // R4 R6
      assign down = (g == NCHAN - 1 && quad_mode) ? q_down : 1'b0; // R4
      assign match_a = ~capture_mode_reg[g] & (count_reg[g] == gen_a_reg[g]) & (up | down); // R14 R7
      assign match_b = count_reg[g] == gen_b_reg[g] & (up | down);
      assign cap_ev = capture_mode_reg[g] & capture_in[g] & ~cap_d_reg[g]; // R15
      assign match_a_ev[g] = match_a | cap_ev;
      assign clr_req = wr_match & ~wdata_reg[g] & a_armed_reg[g]; // R16 R17
      assign set_req = match_a_ev[g];
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          count_reg[g] <= 16'h0000;
        end else if (wr_count[g]) begin
          count_reg[g] <= wdata_reg[15:0];
        end else if (up) begin
          count_reg[g] <= count_reg[g] + 16'h0001;
        end else if (down) begin
          count_reg[g] <= count_reg[g] - 16'h0001;
        end
      end

      always_ff @(posedge clk_sys) begin
        if (rst) begin
          gen_a_reg[g] <= tmas_pkg::GEN_RESET;
        end else if (cap_ev) begin
          gen_a_reg[g] <= count_reg[g]; // R15
        end else if (wr_gen_a[g]) begin
          gen_a_reg[g] <= wdata_reg[15:0];
        end
      end

      always_ff @(posedge clk_sys) begin
        if (rst) begin
          gen_b_reg[g] <= tmas_pkg::GEN_RESET;
        end else if (wr_gen_b[g]) begin
          gen_b_reg[g] <= wdata_reg[15:0];
        end
      end

      always_ff @(posedge clk_sys) begin
        if (rst) begin
          pwm_reg[g] <= 1'b0;
        end else if (~mode_reg[g]) begin
          pwm_reg[g] <= out_init_reg[g];
        end else if (match_a) begin
          pwm_reg[g] <= 1'b1; // R10
        end else if (match_b) begin
          pwm_reg[g] <= 1'b0; // R10
        end
      end

      // set beats clear; clear needs a prior read that saw the flag high
      always_ff @(posedge clk_sys) begin
        if (soft_init) begin
          a_flag_reg[g] <= 1'b0;
          a_armed_reg[g] <= 1'b0;
        end else begin
          if (set_req) begin
            a_flag_reg[g] <= 1'b1; // R14 R15
          end else if (clr_req) begin
            a_flag_reg[g] <= 1'b0; // R16
          end
          if (rd_fire && ra == tmas_pkg::ADDR_MATCH_A && a_flag_reg[g]) begin
            a_armed_reg[g] <= 1'b1;
          end else if (wr_match || ~a_flag_reg[g]) begin
            a_armed_reg[g] <= 1'b0; // R17
          end
        end
      end

      always_ff @(posedge clk_sys) begin
        if (rst) begin
          match_a_irq_reg[g] <= 1'b0;
        end else begin
          match_a_irq_reg[g] <= a_flag_reg[g] & a_en_reg[g]; // R13
        end
      end
    end
  endgenerate
  assign ch2_ovf = g_chan[NCHAN-1].up & (count_reg[NCHAN-1] == tmas_pkg::COUNT_MAX);
  assign ch2_unf = g_chan[NCHAN-1].down & (count_reg[NCHAN-1] == 16'h0000);
  // ----------------------------------------------------------------
  // mode register and enables
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (soft_init) begin
      mode_reg <= tmas_pkg::MODE_RESET; // R1
    end else if (wr_mode) begin
      mode_reg <= wdata_reg[7:0] | tmas_pkg::MODE_FIXED_ONES; // R2 R9
    end
  end
  always_ff @(posedge clk_sys) begin
    if (soft_init) begin
      a_en_reg <= '0; // R11
    end else if (wr_match) begin
      a_en_reg <= wdata_reg[tmas_pkg::MATCH_A_EN_LSB +: NCHAN]; // R13
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      capture_mode_reg <= '0;
      out_init_reg <= '0;
      standby_d_reg <= 1'b0;
      cap_d_reg <= '0;
    end else begin
      standby_d_reg <= standby;
      cap_d_reg <= capture_in;
      if (wr_fire && wa == tmas_pkg::ADDR_CTRL && wstrb_reg[0]) begin
        capture_mode_reg <= wdata_reg[tmas_pkg::CTRL_CAPTURE_LSB +: NCHAN];
        out_init_reg <= wdata_reg[tmas_pkg::CTRL_INIT_LSB +: NCHAN];
      end
    end
  end

  // ----------------------------------------------------------------
  // sticky event status, mask and interrupt line
  // ----------------------------------------------------------------
  logic [3:0] ev_vec;
  logic [3:0] w1c;
  assign ev_vec = {ch2_ovf | (ch2_unf & ~mode_reg[tmas_pkg::MODE_OVF_COND_BIT]), match_a_ev}; // R8
  assign w1c = (wr_fire && wa == tmas_pkg::ADDR_IRQ_STAT) ? wdata_reg[3:0] : 4'h0;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_stat_reg <= 4'h0;
      irq_mask_reg <= 4'h0;
      irq_reg <= 1'b0;
    end else begin
      irq_stat_reg <= ev_vec | (irq_stat_reg & ~w1c);
      if (wr_fire && wa == tmas_pkg::ADDR_IRQ_MASK) begin
        irq_mask_reg <= wdata_reg[3:0];
      end
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
    end
  end
  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= 32'h0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= tmas_pkg::AXI_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_full_reg) begin
        aw_full_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_reg) begin
        w_full_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= (wa > tmas_pkg::ADDR_IRQ_MASK || wa[1:0] != 2'b00) ? tmas_pkg::AXI_SLVERR
                                                                       : tmas_pkg::AXI_OKAY;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  logic [31:0] rd_val;
  logic rd_ok;
  always_comb begin
    rd_val = 32'h0;
    rd_ok = 1'b1;
    case (ra)
      tmas_pkg::ADDR_MODE: rd_val = {24'h0, mode_reg | tmas_pkg::MODE_FIXED_ONES}; // R2
      tmas_pkg::ADDR_MATCH_A: rd_val = {24'h0, tmas_pkg::MATCH_A_FIXED_ONES | 8'({a_en_reg, 1'b0, a_flag_reg})}; // R12
      tmas_pkg::ADDR_CTRL: rd_val = {24'h0, 1'b0, out_init_reg, 1'b0, capture_mode_reg};
      tmas_pkg::ADDR_IRQ_STAT: rd_val = {28'h0, irq_stat_reg};
      tmas_pkg::ADDR_IRQ_MASK: rd_val = {28'h0, irq_mask_reg};
      default: begin
        rd_ok = 1'b0;
        for (int i = 0; i < NCHAN; i++) begin
          if (ra == tmas_pkg::ADDR_COUNT2 + 8'(i) * tmas_pkg::ADDR_GEN_STRIDE) begin
            rd_val = {16'h0, count_reg[i]};
            rd_ok = 1'b1;
          end
          if (ra == tmas_pkg::ADDR_GEN_A + 8'(i) * tmas_pkg::ADDR_GEN_STRIDE) begin
            rd_val = {16'h0, gen_a_reg[i]};
            rd_ok = 1'b1;
          end
          if (ra == tmas_pkg::ADDR_GEN_B + 8'(i) * tmas_pkg::ADDR_GEN_STRIDE) begin
            rd_val = {16'h0, gen_b_reg[i]};
            rd_ok = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= tmas_pkg::AXI_OKAY;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_ok ? rd_val : 32'h0;
      rresp_reg <= rd_ok ? tmas_pkg::AXI_OKAY : tmas_pkg::AXI_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign s_axi_awready = ~aw_full_reg;
  assign s_axi_wready = ~w_full_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign pwm_out_pin = pwm_reg;
  assign match_a_irq = match_a_irq_reg;
  assign irq = irq_reg;
endmodule : tmas_top

/* tb/tmas_top_assertions.sv */
// checker: bus answers and register behaviour seen at the timer ports
`timescale 1ns/100ps
module tmas_checker #(
  parameter int NCHAN = 3
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic standby,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NCHAN-1:0] match_a_irq,
  input wire logic irq
);
  // ----
  // handshake steps
  // ----
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (s_wr_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read data late");
  a_bvalid_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_rvalid_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  a_unmapped_read: assert property (s_rd_taken and (s_axi_araddr > 32'(tmas_pkg::ADDR_IRQ_MASK))
    |=> s_axi_rvalid && s_axi_rresp == tmas_pkg::AXI_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_mode_fixed_ones: assert property (
    s_rd_taken and (s_axi_araddr == 32'(tmas_pkg::ADDR_MODE))
    |=> (s_axi_rdata[7:0] & tmas_pkg::MODE_FIXED_ONES) == tmas_pkg::MODE_FIXED_ONES)
    else $error("mode fixed bits not one");
  a_match_fixed_ones: assert property (
    s_rd_taken and (s_axi_araddr == 32'(tmas_pkg::ADDR_MATCH_A))
    |=> (s_axi_rdata[7:0] & tmas_pkg::MATCH_A_FIXED_ONES) == tmas_pkg::MATCH_A_FIXED_ONES)
    else $error("status fixed bits not one");
  a_reset_quiet: assert property ($fell(rst) |-> match_a_irq == '0 && !irq && !s_axi_bvalid)
    else $error("outputs active after reset");
  a_standby_quiet: assert property ($rose(standby) |-> ##3 match_a_irq == '0)
    else $error("enables survive standby");
endmodule : tmas_checker

bind tmas_top tmas_checker #(.NCHAN(NCHAN)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .standby(standby),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .match_a_irq(match_a_irq), .irq(irq)
);

/* tb/tmas_quad_model.sv */
// partner: quadrature encoder driving the two phase pins
`timescale 1ns/100ps
module tmas_quad_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic step_up,
  input wire logic step_dn,
  output logic quad_input_a,
  output logic quad_input_b
);
  logic [1:0] phase_reg;
  // gray walk, only one pin moves per step so no edge pair is ambiguous
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phase_reg <= 2'h0;
    end else if (step_dn) begin
      phase_reg <= phase_reg + 2'h1;
    end else if (step_up) begin
      phase_reg <= phase_reg - 2'h1;
    end
  end
  assign quad_input_a = phase_reg[0] ^ phase_reg[1];
  assign quad_input_b = phase_reg[1];
endmodule : tmas_quad_model

/* tb/tmas_top_tb.sv */
// testbench: register, match, pwm, quadrature and standby scenarios for the timer block
`timescale 1ns/100ps
module tmas_top_tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic standby = 1'b0;
  logic step_up = 1'b0;
  logic step_dn = 1'b0;
  logic quad_input_a;
  logic quad_input_b;
  logic [2:0] count_tick = 3'h0;
  logic [2:0] capture_in = 3'h0;
  logic [31:0] s_axi_awaddr = 32'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [31:0] s_axi_araddr = 32'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1;
  logic s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp;
  logic [1:0] s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [2:0] pwm_out_pin;
  logic [2:0] match_a_irq;
  logic [31:0] d;
  logic [1:0] r;
  int miscompares = 0;
  int checks_done = 0;

  always #12.5 clk_sys = ~clk_sys;

  tmas_top #(.NCHAN(3)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .standby(standby),
    .quad_input_a(quad_input_a), .quad_input_b(quad_input_b),
    .count_tick(count_tick), .capture_in(capture_in),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pwm_out_pin(pwm_out_pin), .match_a_irq(match_a_irq), .irq(irq)
  );
  tmas_quad_model u_quad (
    .clk_sys(clk_sys), .rst(rst), .step_up(step_up), .step_dn(step_dn),
    .quad_input_a(quad_input_a), .quad_input_b(quad_input_b)
  );

  // ----
  // bus and compare tasks
  // ----
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  task automatic hang();
    miscompares++;
    $display("mismatch at %0t: handshake timeout", $time);
    give_verdict();
  endtask : hang

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // bready and rready stay high, so no strobe is lowered and raised in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    logic aw_p;
    logic w_p;
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    aw_p = 1'b1;
    w_p = 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (n > 50) hang();
      if (aw_p && s_axi_awready) begin
        aw_p = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_p && s_axi_wready) begin
        w_p = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end while (aw_p || w_p || !s_axi_bvalid);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    logic ar_p;
    logic got;
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    ar_p = 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (n > 50) hang();
      got = !ar_p && s_axi_rvalid;
      if (ar_p && s_axi_arready) begin
        ar_p = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
    end while (!got);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk({22'h0, r, d[7:0]}, {22'h0, tmas_pkg::AXI_OKAY, e});
  endtask : rdc

  task automatic tick(input int ch, input int cnt);
    repeat (cnt) begin
      count_tick[ch] <= 1'b1;
      @(posedge clk_sys);
      count_tick[ch] <= 1'b0;
      @(posedge clk_sys);
    end
    repeat (4) @(posedge clk_sys);
  endtask : tick

  // synchroniser needs about three cycles before the edge is counted
  task automatic step(input logic dn);
    step_dn <= dn;
    step_up <= !dn;
    @(posedge clk_sys);
    step_dn <= 1'b0;
    step_up <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask : step

  // ----
  // scenarios
  // ----
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rdc(tmas_pkg::ADDR_MODE, 8'h98);
    rdc(tmas_pkg::ADDR_MATCH_A, 8'h88);
    wr(tmas_pkg::ADDR_MODE, 32'h0);
    rdc(tmas_pkg::ADDR_MODE, 8'h98);
    wr(tmas_pkg::ADDR_MATCH_A, 32'h0);
    rdc(tmas_pkg::ADDR_MATCH_A, 8'h88);
    wr(tmas_pkg::ADDR_MODE, 32'hFF);
    rdc(tmas_pkg::ADDR_MODE, 8'hFF);
    wr(tmas_pkg::ADDR_MODE, 32'h01);
    rdc(tmas_pkg::ADDR_MODE, 8'h99);
    wr(tmas_pkg::ADDR_GEN_A, 32'h5);
    wr(tmas_pkg::ADDR_GEN_B, 32'h7);
    wr(tmas_pkg::ADDR_MATCH_A, 32'h10);
    rdc(tmas_pkg::ADDR_MATCH_A, 8'h98);
    tick(0, 6);
    chk(32'(pwm_out_pin), 32'h1);
    chk(32'(match_a_irq), 32'h1);
    rdc(tmas_pkg::ADDR_MATCH_A, 8'h99);
    tick(0, 2);
    chk(32'(pwm_out_pin), 32'h0);
    wr(tmas_pkg::ADDR_MATCH_A, 32'h11);
    rdc(tmas_pkg::ADDR_MATCH_A, 8'h99);
    wr(tmas_pkg::ADDR_MATCH_A, 32'h10);
    rdc(tmas_pkg::ADDR_MATCH_A, 8'h98);
    chk(32'(match_a_irq), 32'h0);
    wr(tmas_pkg::ADDR_CTRL, 32'h01);
    capture_in[0] <= 1'b1;
    repeat (2) @(posedge clk_sys);
    capture_in[0] <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rd(tmas_pkg::ADDR_GEN_A);
    chk(d, 32'h8);
    wr(tmas_pkg::ADDR_MATCH_A, 32'h10);
    rdc(tmas_pkg::ADDR_MATCH_A, 8'h99);
    wr(tmas_pkg::ADDR_MATCH_A, 32'h10);
    rdc(tmas_pkg::ADDR_MATCH_A, 8'h98);
    wr(tmas_pkg::ADDR_IRQ_MASK, 32'h1);
    repeat (3) @(posedge clk_sys);
    chk(32'(irq), 32'h1);
    wr(tmas_pkg::ADDR_IRQ_MASK, 32'h0);
    repeat (3) @(posedge clk_sys);
    chk(32'(irq), 32'h0);
    wr(tmas_pkg::ADDR_IRQ_MASK, 32'h1);
    wr(tmas_pkg::ADDR_IRQ_STAT, 32'h1);
    repeat (3) @(posedge clk_sys);
    chk(32'(irq), 32'h0);
    wr(tmas_pkg::ADDR_MODE, 32'h40);
    rdc(tmas_pkg::ADDR_MODE, 8'hD8);
    wr(tmas_pkg::ADDR_IRQ_STAT, 32'hF);
    step(1'b1);
    rd(tmas_pkg::ADDR_IRQ_STAT);
    chk(d & 32'h8, 32'h8);
    wr(tmas_pkg::ADDR_IRQ_STAT, 32'h8);
    wr(tmas_pkg::ADDR_MODE, 32'h60);
    step(1'b0);
    rd(tmas_pkg::ADDR_IRQ_STAT);
    chk(d & 32'h8, 32'h8);
    // general A of channel 2 still holds FFFF, so the up step out of FFFF is a match
    rd(tmas_pkg::ADDR_MATCH_A);
    chk(d & 32'h4, 32'h4);
    wr(tmas_pkg::ADDR_IRQ_STAT, 32'h8);
    step(1'b1);
    rd(tmas_pkg::ADDR_IRQ_STAT);
    chk(d & 32'h8, 32'h0);
    tick(2, 1);
    rd(tmas_pkg::ADDR_IRQ_STAT);
    chk(d & 32'h8, 32'h0);
    wr(tmas_pkg::ADDR_MATCH_A, 32'h74);
    repeat (2) @(posedge clk_sys);
    chk(32'(match_a_irq), 32'h4);
    standby <= 1'b1;
    repeat (4) @(posedge clk_sys);
    standby <= 1'b0;
    @(posedge clk_sys);
    rdc(tmas_pkg::ADDR_MODE, 8'h98);
    rdc(tmas_pkg::ADDR_MATCH_A, 8'h88);
    rd(8'h40);
    chk({30'h0, r}, {30'h0, tmas_pkg::AXI_SLVERR});
    chk(d, 32'h0);
    give_verdict();
  end
endmodule : tmas_top_tb
